/* File: design/fault_clear_and_input_current_regs.sv */
/*
  Register bank for overcurrent and external supply good-fail clears and
  the clear-on-read input current conversion result.
  Assumes a serial management front end that presents one byte access
  per request cycle, and an ADC that pulses conv_valid with a result.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fault_clear_cfg.svh"

module fault_clear_and_input_current_regs (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire fault_clear_pkg::reg_req_t req,
  input wire fault_clear_pkg::fault_events_t events,
  input wire logic conv_valid,
  input wire logic [`IIN_WIDTH-1:0] conv_data,
  input wire fault_clear_pkg::current_span_t span_sel,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic [`OC_SOURCES-1:0] overcurrent_flags,
  output logic [`PG_SOURCES-1:0] good_fail_flags,
  output fault_clear_pkg::current_span_t result_span
);

  // ************************************************************
  // state
  // ************************************************************
  logic [`OC_SOURCES-1:0] oc_flag_reg;
  wire logic [`OC_SOURCES-1:0] oc_flag_next;
  logic [`PG_SOURCES-1:0] pg_flag_reg;
  wire logic [`PG_SOURCES-1:0] pg_flag_next;
  logic [7:0] iin_low_reg;
  logic [7:0] iin_low_next;
  logic [`IIN_HIGH_MSB:0] iin_high_reg;
  logic [`IIN_HIGH_MSB:0] iin_high_next;
  fault_clear_pkg::current_span_t span_reg;
  fault_clear_pkg::current_span_t span_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;

  // ************************************************************
  // address decode
  // ************************************************************
  wire logic hit_oc_clr;
  wire logic hit_pg_clr;
  wire logic hit_low;
  wire logic hit_high;
  wire logic wr_oc_clr;
  wire logic wr_pg_clr;
  wire logic rd_low;
  wire logic rd_high;

  assign hit_oc_clr = (req.addr == `OFS_OVERCURRENT_IRQ_CLEAR);
  assign hit_pg_clr = (req.addr == `OFS_EXT_GOOD_FAIL_IRQ_CLEAR);
  assign hit_low = (req.addr == `OFS_INPUT_CURRENT_RESULT_LOW);
  assign hit_high = (req.addr == `OFS_INPUT_CURRENT_RESULT_HIGH);
  assign wr_oc_clr = req.wr & hit_oc_clr;
  assign wr_pg_clr = req.wr & hit_pg_clr;
  assign rd_low = req.rd & hit_low;
  assign rd_high = req.rd & hit_high;

  // ************************************************************
  // clear masks
  // ************************************************************
  // bit order: index 6 is the input supply, index 0 the linear regulator
  wire logic [`OC_SOURCES-1:0] oc_clear;
  wire logic [`PG_SOURCES-1:0] pg_clear;

  // bits 7..1 map onto the seven sources
  assign oc_clear = wr_oc_clr ?
    req.wdata[`OC_CLR_MSB:`OC_CLR_LSB] : `RST_OC_FLAGS;
  // bits 7..5 map onto supplies one to three
  assign pg_clear = wr_pg_clr ?
    req.wdata[`PG_CLR_MSB:`PG_CLR_LSB] : `RST_PG_FLAGS;

  // ************************************************************
  // sticky flags
  // ************************************************************
  // a new event in the clear cycle wins, so no fault is lost to a clear; events seen while ce is low are dropped
  genvar i;
  generate
    for (i = 0; i < `OC_SOURCES; i = i + 1)
    begin : g_oc
      // set holds until a clear, set beats clear
      assign oc_flag_next[i] = events.overcurrent[i] |
        (oc_flag_reg[i] & ~oc_clear[i]);
    end
    for (i = 0; i < `PG_SOURCES; i = i + 1)
    begin : g_pg
      // set holds until a clear, set beats clear
      assign pg_flag_next[i] = events.good_fail[i] |
        (pg_flag_reg[i] & ~pg_clear[i]);
    end
  endgenerate

  // ************************************************************
  // conversion result
  // ************************************************************
  // a conversion landing in the read cycle replaces the data, so the
  // fresh sample survives instead of being wiped by the read
  // low byte loaded on conversion, cleared on read
  assign iin_low_next = conv_valid ? conv_data[7:0] :
    (rd_low ? `RST_BYTE : iin_low_reg);
  // high bits loaded on conversion, cleared on read
  assign iin_high_next = conv_valid ? conv_data[`IIN_WIDTH-1:8] :
    (rd_high ? `RST_IIN_HIGH : iin_high_reg);
  assign span_next = conv_valid ? span_sel : span_reg;

  // ************************************************************
  // read data
  // ************************************************************
  // clear bits are strobes and reserved bits hold nothing: both read 0
  wire logic [7:0] high_byte;
  assign high_byte = {5'h00, iin_high_reg};
  assign rdata_next = rd_low ? iin_low_reg :
    (rd_high ? high_byte : `RST_BYTE);

  // ************************************************************
  // flops
  // ************************************************************
  // one short block per register; ce low holds all of them, reads too,
  // so a read strobe seen while frozen is neither answered nor cleared
  // overcurrent flag storage
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      oc_flag_reg <= `RST_OC_FLAGS;
    end
    else if (ce)
    begin
      oc_flag_reg <= oc_flag_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pg_flag_reg <= `RST_PG_FLAGS;
    end
    else if (ce)
    begin
      pg_flag_reg <= pg_flag_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      iin_low_reg <= `RST_BYTE;
    end
    else if (ce)
    begin
      iin_low_reg <= iin_low_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      iin_high_reg <= `RST_IIN_HIGH;
    end
    else if (ce)
    begin
      iin_high_reg <= iin_high_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      span_reg <= fault_clear_pkg::SPAN_1A5;
    end
    else if (ce)
    begin
      span_reg <= span_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rdata_reg <= `RST_BYTE;
    end
    else if (ce)
    begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rvalid_reg <= 1'b0;
    end
    else if (ce)
    begin
      rvalid_reg <= req.rd;
    end
  end

  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;
  assign overcurrent_flags = oc_flag_reg;
  assign good_fail_flags = pg_flag_reg;
  assign result_span = span_reg;

endmodule // fault_clear_and_input_current_regs

`default_nettype wire

/* File: design/fault_clear_cfg.svh */
/*
  Offsets, field positions, widths and reset values of the fault clear
  and input current result registers.
  Assumes it is included by bare name wherever the register map is needed.
*/
`ifndef FAULT_CLEAR_CFG_SVH
`define FAULT_CLEAR_CFG_SVH

// ************************************************************
// register offsets
// ************************************************************
`define OFS_OVERCURRENT_IRQ_CLEAR 8'h10
`define OFS_EXT_GOOD_FAIL_IRQ_CLEAR 8'h11
`define OFS_INPUT_CURRENT_RESULT_LOW 8'h12
`define OFS_INPUT_CURRENT_RESULT_HIGH 8'h13

// ************************************************************
// field layout
// ************************************************************
`define OC_CLR_MSB 7
`define OC_CLR_LSB 1
`define PG_CLR_MSB 7
`define PG_CLR_LSB 5
`define IIN_HIGH_MSB 2
`define OC_SOURCES 7
`define PG_SOURCES 3
`define IIN_WIDTH 11

// ************************************************************
// reset values
// ************************************************************
`define RST_BYTE 8'h00
`define RST_OC_FLAGS 7'h00
`define RST_PG_FLAGS 3'h0
`define RST_IIN 11'h000
`define RST_IIN_HIGH 3'h0

`endif

/* File: design/fault_clear_pkg.sv */
/*
  Types shared by the fault clear and input current register bank.
  Assumes fault_clear_cfg.svh is available on the include path.
*/
`default_nettype none
`include "fault_clear_cfg.svh"

package fault_clear_pkg;

  // ************************************************************
  // register access request from the serial front end
  // ************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // ************************************************************
  // raw fault events, one bit per source, high for one cycle
  // ************************************************************
  typedef struct packed {
    logic [`OC_SOURCES-1:0] overcurrent;
    logic [`PG_SOURCES-1:0] good_fail;
  } fault_events_t;

  // measurement span of a conversion
  typedef enum logic {
    SPAN_1A5 = 1'b0,
    SPAN_6A = 1'b1
  } current_span_t;

endpackage

`default_nettype wire

/* File: tb/fault_clear_monitor.sv */
/* checker for the fault clear and current result bank.
   assumes it is bound onto the bank's top module. */
`timescale 1ns/100ps
`default_nettype none
module fault_clear_monitor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire fault_clear_pkg::reg_req_t req,
  input wire fault_clear_pkg::fault_events_t events,
  input wire logic conv_valid,
  input wire fault_clear_pkg::current_span_t span_sel,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [6:0] overcurrent_flags,
  input wire logic [2:0] good_fail_flags,
  input wire fault_clear_pkg::current_span_t result_span
);
  // ****
  // clear masks
  // ****
  wire logic [6:0] oc_clr;
  wire logic [2:0] pg_clr;
  assign oc_clr = (req.wr && req.addr == 8'h10) ? req.wdata[7:1] : 7'h00;
  assign pg_clr = (req.wr && req.addr == 8'h11) ? req.wdata[7:5] : 3'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_rd_answered: assert property (ce && req.rd |=> rvalid)
    else $error("read not answered");
  a_rdata_idle: assert property (ce && !req.rd |=> rdata == 8'h00)
    else $error("read data stands too long");
  a_high_reserved: assert property (
    ce && req.rd && req.addr == 8'h13 |=> rdata[7:3] == 5'h00)
    else $error("reserved high bits set");
  a_oc_set: assert property (ce |=> (overcurrent_flags & $past(
    events.overcurrent)) == $past(events.overcurrent))
    else $error("overcurrent event not latched");
  a_oc_keep: assert property (
    ce |=> (overcurrent_flags & $past(overcurrent_flags & ~oc_clr)) ==
    $past(overcurrent_flags & ~oc_clr)
    && (overcurrent_flags & $past(oc_clr & ~events.overcurrent)) == 7'h00)
    else $error("overcurrent flag wrongly kept or lost");
  a_pg_set: assert property (ce |=> (good_fail_flags & $past(
    events.good_fail)) == $past(events.good_fail))
    else $error("good-fail event not latched");
  a_pg_keep: assert property (
    ce |=> (good_fail_flags & $past(good_fail_flags & ~pg_clr)) ==
    $past(good_fail_flags & ~pg_clr)
    && (good_fail_flags & $past(pg_clr & ~events.good_fail)) == 3'h0)
    else $error("good-fail flag wrongly kept or lost");
  a_span_taken: assert property (ce && conv_valid
    |=> result_span == $past(span_sel))
    else $error("span not captured");
  cover property (ce && req.rd && req.addr == 8'h12);
  cover property (ce && conv_valid);
  cover property (ce && oc_clr != 7'h00);
  a_freeze_hold: assert property (
    !ce |=> $stable(rdata) && $stable(rvalid) &&
    $stable(overcurrent_flags) && $stable(good_fail_flags) &&
    $stable(result_span))
    else $error("state moved while clock enable low");
  cover property (!ce);
endmodule // fault_clear_monitor
bind fault_clear_and_input_current_regs fault_clear_monitor mon (
  .mclk(mclk), .rstn(rstn), .ce(ce), .req(req), .events(events),
  .conv_valid(conv_valid), .span_sel(span_sel), .rdata(rdata),
  .rvalid(rvalid), .overcurrent_flags(overcurrent_flags),
  .good_fail_flags(good_fail_flags), .result_span(result_span));
`default_nettype wire

/* File: tb/mgmt_host.sv */
/* host model issuing single byte accesses to the bank.
   assumes the bank answers a read at the edge after it is taken. */
`timescale 1ns/100ps
`default_nettype none
module mgmt_host (
  input wire logic mclk,
  output var fault_clear_pkg::reg_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
    // idle address and data are scrambled, not held
    @(posedge mclk) req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) req <= '{1'b0, 1'b0, ~a, 8'hFF};
    #1 d = rdata;
  endtask
endmodule // mgmt_host
`default_nettype wire

/* File: tb/test_fault_clear_and_input_current_regs.sv */
/* directed test of clears, sticky flags and clear-on-read results.
   assumes the host model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module test_fault_clear_and_input_current_regs;
  logic mclk, rstn, ce, conv_valid, rvalid;
  fault_clear_pkg::reg_req_t req;
  fault_clear_pkg::fault_events_t events;
  fault_clear_pkg::current_span_t span_sel, span;
  logic [10:0] conv_data;
  logic [7:0] rdata, d;
  logic [6:0] oc;
  logic [2:0] pg;
  int error_cnt, checks_done;
  fault_clear_and_input_current_regs uut (.mclk(mclk), .rstn(rstn),
    .ce(ce), .req(req), .events(events), .conv_valid(conv_valid),
    .conv_data(conv_data), .span_sel(span_sel), .rdata(rdata),
    .rvalid(rvalid), .overcurrent_flags(oc), .good_fail_flags(pg),
    .result_span(span));
  mgmt_host host (.mclk(mclk), .req(req), .rdata(rdata));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d);
    check(8'(rvalid), 8'h01);
    check(d, exp);
  endtask
  task conv(input logic [10:0] v, input fault_clear_pkg::current_span_t s);
    @(posedge mclk) conv_valid <= 1'b1;
    conv_data <= v;
    span_sel <= s;
    @(posedge mclk) conv_valid <= 1'b0;
    #1 check(8'(span), 8'(s));
  endtask
  initial
  begin
    {rstn, conv_valid, conv_data, events} = '0;
    ce = 1'b1;
    span_sel = fault_clear_pkg::SPAN_1A5;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    conv(11'h5A3, fault_clear_pkg::SPAN_6A);
    rdchk(8'h12, 8'hA3);
    rdchk(8'h12, 8'h00);
    rdchk(8'h13, 8'h05);
    rdchk(8'h13, 8'h00);
    conv(11'h7FF, fault_clear_pkg::SPAN_1A5);
    rdchk(8'h13, 8'h07);
    rdchk(8'h12, 8'hFF);
    check(8'(oc), 8'h00);
    check(8'(pg), 8'h00);
    @(posedge mclk) events <= '{7'h7F, 3'h7};
    @(posedge mclk) events <= '0;
    #1 check(8'(oc), 8'h7F);
    check(8'(pg), 8'h07);
    host.wr(8'h10, 8'h00);
    #1 check(8'(oc), 8'h7F);
    host.wr(8'h10, 8'h80);
    #1 check(8'(oc), 8'h3F);
    host.wr(8'h10, 8'h7F);
    #1 check(8'(oc), 8'h00);
    host.wr(8'h11, 8'h1F);
    #1 check(8'(pg), 8'h07);
    host.wr(8'h11, 8'hA0);
    #1 check(8'(pg), 8'h02);
    rdchk(8'h10, 8'h00);
    rdchk(8'h11, 8'h00);
    rdchk(8'h20, 8'h00);
    host.wr(8'h11, 8'h40);
    #1 check(8'(pg), 8'h00);
    @(posedge mclk) ce <= 1'b0;
    events <= '{7'h7F, 3'h7};
    @(posedge mclk) events <= '0;
    #1 check(8'(oc), 8'h00);
    check(8'(pg), 8'h00);
    @(posedge mclk) ce <= 1'b1;
    @(posedge mclk) events <= '{7'h41, 3'h4};
    @(posedge mclk) events <= '0;
    rstn <= 1'b0;
    #1 check(8'(oc), 8'h41);
    check(8'(pg), 8'h04);
    @(posedge mclk) rstn <= 1'b1;
    #1 check(8'(oc), 8'h00);
    check(8'(pg), 8'h00);
    print_verdict();
  end
  initial
  begin
    #5000;
    error_cnt++;
    print_verdict();
  end
endmodule // test_fault_clear_and_input_current_regs
`default_nettype wire
